/* File: hw/ctw_timer_defs.vh */
// register map, field positions, reset values and timing counts
`ifndef CTW_TIMER_DEFS_VH
`define CTW_TIMER_DEFS_VH
// register byte offsets
`define CTW_STATUS_CONTROL_ADDR 4'h0
`define CTW_COUNT_VALUE_ADDR    4'h4
`define CTW_WATCHDOG_CLEAR_ADDR 4'h8
`define CTW_MODE_CONTROL_ADDR   4'hc
// status/control field positions
`define CTW_OVF_FLAG_BIT        7
`define CTW_PER_FLAG_BIT        6
`define CTW_OVF_IE_BIT          5
`define CTW_PER_IE_BIT          4
`define CTW_OVF_FLAG_RST_BIT    3
`define CTW_PER_FLAG_RST_BIT    2
`define CTW_RATE_HI_BIT         1
`define CTW_RATE_LO_BIT         0
`define CTW_RATE_RESET          2'h3
// watchdog clear bit in the clear register
`define CTW_WDOG_CLEAR_BIT      0
// mode control field: stop request only
`define CTW_MODE_STOP_BIT       0
// chain geometry
`define CTW_PRESCALE_DIV        3'h3
`define CTW_CHAIN_STAGES        15
`define CTW_WDOG_STAGES         4
`define CTW_WDOG_TIMEOUT        3'h7
// startup delay in bus cycles, short and long
`define CTW_STARTUP_SHORT       16
`define CTW_STARTUP_LONG        4064
// bus response codes
`define CTW_RESP_OKAY           2'h0
`define CTW_RESP_SLVERR         2'h2
`endif

/* File: hw/ctw_ripple_chain.v */
// prescaler and 15-stage counter chain with per-stage enables
`timescale 1ns/1ns
module ctw_ripple_chain (
   // clock and reset
   input  wire        core_clk,
   input  wire        rst_b,
   // control
   input  wire        chainClear,
   // outputs
   output reg  [14:0] stageCount,
   output wire        stageTick,
   output wire [14:0] stageCarry
);
`include "ctw_timer_defs.vh"

   reg  [1:0] prescaleReg;
   wire       prescaleTick;

   // four bus cycles equal eight oscillator cycles per count
   assign prescaleTick = (prescaleReg == 2'h3); // RULE14

   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         prescaleReg <= 2'h0;
      end else if (chainClear) begin
         prescaleReg <= 2'h0;
      end else begin
         prescaleReg <= prescaleReg + 2'h1;
      end
   end

   assign stageTick = prescaleTick;

   // each stage toggles when all lower stages are ones; synchronous form
   genvar i;
   generate
      for (i = 0; i < `CTW_CHAIN_STAGES; i = i + 1) begin : g_stage
         if (i == 0) begin : g_first
            assign stageCarry[i] = prescaleTick;
         end else begin : g_rest
            assign stageCarry[i] = stageCarry[i-1] & stageCount[i-1];
         end
         always @(posedge core_clk or negedge rst_b) begin
            if (!rst_b) begin
               stageCount[i] <= 1'b0;
            end else if (chainClear) begin
               stageCount[i] <= 1'b0;
            end else if (stageCarry[i]) begin
               stageCount[i] <= ~stageCount[i]; // RULE22
            end
         end
      end
   endgenerate
endmodule

/* File: hw/ctw_watchdog.v */
// four-stage watchdog counter clocked by the selected periodic tap
`timescale 1ns/1ns
module ctw_watchdog (
   // clock and reset
   input  wire       core_clk,
   input  wire       rst_b,
   // control
   input  wire       wdogEnable,
   input  wire       wdogClear,
   input  wire       wdogStopped,
   input  wire       rateTick,
   // outputs
   output reg  [2:0] wdogCount,
   output reg        wdogTimeout
);
`include "ctw_timer_defs.vh"

   // timeout falls on the eighth tick, 7 to 8 periods after a clear
   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         wdogCount   <= 3'h0;
         wdogTimeout <= 1'b0;
      end else if (!wdogEnable || wdogStopped || wdogClear) begin
         wdogCount   <= 3'h0; // RULE17 RULE19
         wdogTimeout <= 1'b0;
      end else if (rateTick) begin // RULE10 RULE18
         if (wdogCount == `CTW_WDOG_TIMEOUT) begin
            wdogTimeout <= 1'b1; // RULE11 RULE16
         end
         wdogCount <= wdogCount + 3'h1;
      end else begin
         wdogTimeout <= 1'b0;
      end
   end
endmodule

/* File: hw/ctw_core_timer.v */
// core timer with periodic interrupt, watchdog and AXI4-Lite registers
// What this block does
// RULE1: overflow flag sets on low-byte wrap; reset clears
// RULE2: overflow interrupt when flag and enable set
// RULE3: writing overflow reset bit clears flag only
// RULE4: periodic flag sets on selected tap; interrupt
// RULE5: writing periodic reset bit clears periodic flag
// RULE6: both interrupt enables read/write, reset clears
// RULE7: flag reset bits write-only, read zero
// RULE8: rate select picks divide 2^15 to 2^18
// RULE9: reset sets rate select to longest
// RULE10: selected periodic tap clocks the watchdog
// RULE11: watchdog times out after 7 to 8 periods
// RULE12: software clears watchdog before changing rate
// RULE13: 15-stage chain, low byte readable
// RULE14: one count per four bus cycles
// RULE15: startup delay then chain cleared, reset released
// RULE16: enabled watchdog resets device on timeout
// RULE17: writing zero to clear bit restarts watchdog
// RULE18: watchdog runs in run, wait, halt
// RULE19: stop clears watchdog and gates its clock
// RULE20: halt option turns stop into halt
// RULE21: interrupt requests are level outputs
// RULE22: chain is synchronous with stage enables
`timescale 1ns/1ns
module ctw_core_timer #(
   parameter STARTUP_SHORT = `CTW_STARTUP_SHORT,
   parameter STARTUP_LONG  = `CTW_STARTUP_LONG
) (
   // clock and reset
   input  wire        core_clk,
   input  wire        rst_b,
   // mask options, straps
   input  wire        optWdogEnable,
   input  wire        optHaltForStop,
   input  wire        optLongStartup,
   // axi4-lite write address
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   input  wire [3:0]  s_axi_awaddr,
   // axi4-lite write data
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   // axi4-lite write response
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   output reg  [1:0]  s_axi_bresp,
   // axi4-lite read address
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   input  wire [3:0]  s_axi_araddr,
   // axi4-lite read data
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   // interrupt requests and reset out
   output wire        overflowIrq,
   output wire        periodicIrq,
   output reg         deviceReset,
   output wire        stopActive
);
`include "ctw_timer_defs.vh"

   localparam ST_STARTUP = 2'h0;
   localparam ST_RUN     = 2'h1;

   // straps pass two flip-flops before use
   reg  [2:0]  optMeta;
   reg  [2:0]  optSync;
   reg  [1:0]  stateReg;
   reg  [11:0] startCnt;
   reg         overflow_flag;
   reg         periodic_flag;
   reg         overflow_irq_enable;
   reg         periodic_irq_enable;
   reg  [1:0]  rateSelReg;
   reg         stopReg;
   reg         awHeld;
   reg         wHeld;
   reg  [3:0]  awAddrReg;
   reg  [31:0] wDataReg;
   reg  [3:0]  wStrbReg;
   reg         chainClearReg;
   wire [14:0] stageCount;
   wire [14:0] stageCarry;
   wire        stageTick;
   wire        overflowEvent;
   wire        periodicTick;
   wire        wdogTimeout;
   wire [2:0]  wdogCount;
   wire        doWrite;
   wire        wrLane0;
   wire [31:0] wrData;
   wire [3:0]  wrAddr;
   wire        wdogClear;
   wire        wdogStopped;
   wire [11:0] startLimit;
   wire [7:0]  statusByte;

   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         optMeta <= 3'h0;
         optSync <= 3'h0;
      end else begin
         optMeta <= {optLongStartup, optHaltForStop, optWdogEnable};
         optSync <= optMeta;
      end
   end

   // startup delay, then chain cleared again as reset is released
   assign startLimit = optSync[2] ? STARTUP_LONG[11:0] - 12'h1
                                  : STARTUP_SHORT[11:0] - 12'h1;

   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         stateReg      <= ST_STARTUP;
         startCnt      <= 12'h0;
         deviceReset   <= 1'b1;
         chainClearReg <= 1'b1;
      end else begin
         chainClearReg <= 1'b0;
         case (stateReg)
            ST_STARTUP: begin
               if (startCnt == startLimit) begin
                  stateReg      <= ST_RUN; // RULE15
                  deviceReset   <= 1'b0;
                  chainClearReg <= 1'b1;
               end else begin
                  startCnt <= startCnt + 12'h1;
               end
            end
            ST_RUN: begin
               deviceReset <= 1'b0;
               if (wdogTimeout) begin
                  stateReg      <= ST_STARTUP; // RULE16
                  startCnt      <= 12'h0;
                  deviceReset   <= 1'b1;
                  chainClearReg <= 1'b1;
               end
            end
            default: begin
               stateReg <= ST_STARTUP;
            end
         endcase
      end
   end

   ctw_ripple_chain u_chain (
      .core_clk   (core_clk),
      .rst_b      (rst_b),
      .chainClear (chainClearReg),
      .stageCount (stageCount),
      .stageTick  (stageTick),
      .stageCarry (stageCarry)
   );

   // low eight stages wrap from ff to 00
   assign overflowEvent = stageCarry[7] & stageCount[7]; // RULE1 RULE13

   // taps 2^15..2^18 of oscillator = chain stages 11..14 wrapping
   assign periodicTick = stageCarry[11 + rateSelReg] &
                         stageCount[11 + rateSelReg]; // RULE8

   // halt option turns a stop into a halt, so the watchdog keeps going
   assign wdogStopped = stopReg & ~optSync[1]; // RULE19 RULE20
   assign stopActive  = wdogStopped;

   ctw_watchdog u_wdog (
      .core_clk    (core_clk),
      .rst_b       (rst_b),
      .wdogEnable  (optSync[0] & ~deviceReset),
      .wdogClear   (wdogClear),
      .wdogStopped (wdogStopped),
      .rateTick    (periodicTick),
      .wdogCount   (wdogCount),
      .wdogTimeout (wdogTimeout)
   );

   // write channels are held until both have arrived
   assign s_axi_awready = ~awHeld & ~s_axi_bvalid;
   assign s_axi_wready  = ~wHeld & ~s_axi_bvalid;
   assign wrAddr  = awHeld ? awAddrReg : s_axi_awaddr;
   assign wrData  = wHeld ? wDataReg : s_axi_wdata;
   assign doWrite = (awHeld | (s_axi_awvalid & s_axi_awready)) &
                    (wHeld | (s_axi_wvalid & s_axi_wready));
   assign wrLane0 = wHeld ? wStrbReg[0] : s_axi_wstrb[0];

   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         awHeld       <= 1'b0;
         wHeld        <= 1'b0;
         awAddrReg    <= 4'h0;
         wDataReg     <= 32'h0;
         wStrbReg     <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `CTW_RESP_OKAY;
      end else begin
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         if (doWrite) begin
            awHeld       <= 1'b0;
            wHeld        <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (wrAddr[1:0] == 2'h0 && wrAddr <= 4'hc) ?
                            `CTW_RESP_OKAY : `CTW_RESP_SLVERR;
         end else begin
            if (s_axi_awvalid && s_axi_awready) begin
               awHeld    <= 1'b1;
               awAddrReg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
               wHeld    <= 1'b1;
               wDataReg <= s_axi_wdata;
               wStrbReg <= s_axi_wstrb;
            end
         end
      end
   end

   // watchdog restarts on a zero written to its clear bit
   assign wdogClear = doWrite & wrLane0 &
                      (wrAddr == `CTW_WATCHDOG_CLEAR_ADDR) &
                      ~wrData[`CTW_WDOG_CLEAR_BIT]; // RULE17

   // flags: a set in the same cycle as a clear wins
   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         overflow_flag       <= 1'b0;
         periodic_flag       <= 1'b0;
         overflow_irq_enable <= 1'b0;
         periodic_irq_enable <= 1'b0;
         rateSelReg          <= `CTW_RATE_RESET; // RULE9
         stopReg             <= 1'b0;
      end else if (deviceReset) begin
         overflow_flag       <= 1'b0; // RULE1 RULE4
         periodic_flag       <= 1'b0;
         overflow_irq_enable <= 1'b0; // RULE6
         periodic_irq_enable <= 1'b0;
         rateSelReg          <= `CTW_RATE_RESET;
         stopReg             <= 1'b0;
      end else begin
         if (overflowEvent) begin
            overflow_flag <= 1'b1; // RULE1
         end else if (doWrite && wrLane0 &&
                      wrAddr == `CTW_STATUS_CONTROL_ADDR &&
                      wrData[`CTW_OVF_FLAG_RST_BIT]) begin
            overflow_flag <= 1'b0; // RULE3
         end
         if (periodicTick) begin
            periodic_flag <= 1'b1; // RULE4
         end else if (doWrite && wrLane0 &&
                      wrAddr == `CTW_STATUS_CONTROL_ADDR &&
                      wrData[`CTW_PER_FLAG_RST_BIT]) begin
            periodic_flag <= 1'b0; // RULE5
         end
         if (doWrite && wrLane0 &&
             wrAddr == `CTW_STATUS_CONTROL_ADDR) begin
            overflow_irq_enable <= wrData[`CTW_OVF_IE_BIT]; // RULE6
            periodic_irq_enable <= wrData[`CTW_PER_IE_BIT];
            rateSelReg <= wrData[`CTW_RATE_HI_BIT:`CTW_RATE_LO_BIT];
         end
         if (doWrite && wrLane0 &&
             wrAddr == `CTW_MODE_CONTROL_ADDR) begin
            stopReg <= wrData[`CTW_MODE_STOP_BIT];
         end
      end
   end

   // level requests toward the processor
   assign overflowIrq = overflow_flag & overflow_irq_enable; // RULE2 RULE21
   assign periodicIrq = periodic_flag & periodic_irq_enable; // RULE4 RULE21

   // reset bits always read zero
   assign statusByte = {overflow_flag, periodic_flag,
                        overflow_irq_enable, periodic_irq_enable,
                        2'h0, rateSelReg}; // RULE7

   assign s_axi_arready = ~s_axi_rvalid;

   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0;
         s_axi_rresp  <= `CTW_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= `CTW_RESP_OKAY;
         case (s_axi_araddr)
            `CTW_STATUS_CONTROL_ADDR: s_axi_rdata <= {24'h0, statusByte};
            `CTW_COUNT_VALUE_ADDR: begin
               s_axi_rdata <= {24'h0, stageCount[7:0]}; // RULE13
            end
            `CTW_WATCHDOG_CLEAR_ADDR: s_axi_rdata <= 32'h0;
            `CTW_MODE_CONTROL_ADDR: s_axi_rdata <= {31'h0, stopReg};
            default: begin
               s_axi_rdata <= 32'h0;
               s_axi_rresp <= `CTW_RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule

/* File: bench/ctw_core_timer_chk.sv */
// port-level checks for the core timer and its register bus
`timescale 1ns/1ns
`include "ctw_timer_defs.vh"
module ctw_core_timer_chk #(
   parameter STARTUP_SHORT = 16,
   parameter STARTUP_LONG  = 4064
) (
   // clock, reset, option
   input wire        core_clk,
   input wire        rst_b,
   input wire        optHaltForStop,
   // register bus
   input wire        s_axi_awvalid,
   input wire        s_axi_awready,
   input wire        s_axi_wvalid,
   input wire        s_axi_wready,
   input wire        s_axi_bvalid,
   input wire        s_axi_bready,
   input wire        s_axi_arvalid,
   input wire        s_axi_arready,
   input wire [3:0]  s_axi_araddr,
   input wire        s_axi_rvalid,
   input wire        s_axi_rready,
   input wire [31:0] s_axi_rdata,
   input wire [1:0]  s_axi_rresp,
   // requests and reset out
   input wire        overflowIrq,
   input wire        periodicIrq,
   input wire        deviceReset,
   input wire        stopActive
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   sequence sRdTake;
      s_axi_arvalid && s_axi_arready;
   endsequence
   sequence sWrTake;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   chk_read_answer: assert property (sRdTake |=> s_axi_rvalid)
      else $error("read answer late");
   chk_write_answer: assert property (sWrTake |=> s_axi_bvalid)
      else $error("write answer late");
   chk_rvalid_drop: assert property (s_axi_rvalid && s_axi_rready
      |=> !s_axi_rvalid) else $error("read answered twice");
   chk_bvalid_drop: assert property (s_axi_bvalid && s_axi_bready
      |=> !s_axi_bvalid) else $error("write answered twice");
   chk_bad_addr: assert property (sRdTake ##0 s_axi_araddr[1:0] != 2'h0
      |=> s_axi_rresp == `CTW_RESP_SLVERR && s_axi_rdata == 32'h0)
      else $error("unaligned read not refused");
   chk_reset_bits_zero: assert property (
      sRdTake ##0 s_axi_araddr == `CTW_STATUS_CONTROL_ADDR
      |=> s_axi_rdata[3:2] == 2'h0) else $error("reset bits read one");
   chk_clear_reads_zero: assert property (
      sRdTake ##0 s_axi_araddr == `CTW_WATCHDOG_CLEAR_ADDR
      |=> s_axi_rdata == 32'h0) else $error("clear register readable");
   chk_startup_hold: assert property (
      $rose(rst_b) |-> deviceReset [*8]) else $error("startup too short");
   chk_wdog_reset_len: assert property (
      $rose(deviceReset) |-> deviceReset [*8])
      else $error("watchdog reset too short");
   chk_halt_no_stop: assert property (
      optHaltForStop [*5] |-> !stopActive) else $error("halt option ignored");
   chk_irq_in_reset: assert property (
      deviceReset [*2] |-> !overflowIrq && !periodicIrq)
      else $error("request during reset");
endmodule
bind ctw_core_timer ctw_core_timer_chk #(
   .STARTUP_SHORT(STARTUP_SHORT),
   .STARTUP_LONG(STARTUP_LONG)
) u_chk (
   .core_clk(core_clk), .rst_b(rst_b), .optHaltForStop(optHaltForStop),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rresp(s_axi_rresp), .overflowIrq(overflowIrq),
   .periodicIrq(periodicIrq), .deviceReset(deviceReset),
   .stopActive(stopActive));

/* File: bench/tb_top.sv */
// self-checking bench for the core timer, watchdog and register bus
`timescale 1ns/1ns
`include "ctw_timer_defs.vh"
module tb_top;
   localparam [3:0] ADR_SC = `CTW_STATUS_CONTROL_ADDR;
   localparam [3:0] ADR_WD = `CTW_WATCHDOG_CLEAR_ADDR;
   reg         core_clk = 1'b0, rst_b = 1'b0, longOpt = 1'b0;
   reg         haltOpt = 1'b0, awValid = 1'b0, wValid = 1'b0;
   reg         bReady = 1'b0, arValid = 1'b0, rReady = 1'b0;
   reg  [3:0]  awAddr = 4'h0, arAddr = 4'h0, wStrb = 4'hf;
   reg  [31:0] wData = 32'h0, rd;
   reg  [1:0]  rs;
   reg         pa, pw, pb;
   wire        awReady, wReady, bValid, arReady, rValid;
   wire        ovfIrq, perIrq, devRst, stopAct;
   wire [1:0]  bResp, rResp;
   wire [31:0] rData;
   wire [2:0]  sigs = {devRst, perIrq, ovfIrq};
   integer     errors = 0, n_checks = 0, cyc = 0, a, i, n;
   // long startup cut to 40 cycles keeps the second startup cheap
   ctw_core_timer #(.STARTUP_SHORT(16), .STARTUP_LONG(40)) dut (
      .core_clk(core_clk), .rst_b(rst_b), .optWdogEnable(1'b1),
      .optHaltForStop(haltOpt), .optLongStartup(longOpt),
      .s_axi_awvalid(awValid), .s_axi_awready(awReady),
      .s_axi_awaddr(awAddr), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
      .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_bvalid(bValid),
      .s_axi_bready(bReady), .s_axi_bresp(bResp), .s_axi_arvalid(arValid),
      .s_axi_arready(arReady), .s_axi_araddr(arAddr), .s_axi_rvalid(rValid),
      .s_axi_rready(rReady), .s_axi_rdata(rData), .s_axi_rresp(rResp),
      .overflowIrq(ovfIrq), .periodicIrq(perIrq), .deviceReset(devRst),
      .stopActive(stopAct));
   initial begin
      forever #25 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
   end
   task end_sim;
      begin
         if (errors == 0 && n_checks > 0)
            $display("Testbench passed");
         else
            $display("Testbench failed");
         $finish;
      end
   endtask
   task cmp(input [63:0] nm, input [31:0] e, input [31:0] g);
      begin
         n_checks = n_checks + 1;
         if (g !== e) begin
            errors = errors + 1;
            $display("ERROR %0s exp %h got %h", nm, e, g);
         end
      end
   endtask
   task cmpIn(input [63:0] nm, input integer lo, hi, g);
      begin
         n_checks = n_checks + 1;
         if (g < lo || g > hi) begin
            errors = errors + 1;
            $display("ERROR %0s exp %0d..%0d got %0d", nm, lo, hi, g);
         end
      end
   endtask
   task hang(input integer lim);
      begin
         n = n + 1;
         if (n > lim) begin
            cmp("timeout", 1, 0);
            end_sim;
         end
      end
   endtask
   // sampled on the falling edge so registered outputs have settled
   task waitSig(input integer s, input v, input integer lim);
      begin
         n = 0;
         @(negedge core_clk);
         while (sigs[s] !== v) begin
            @(negedge core_clk);
            hang(lim);
         end
      end
   endtask
   task wr(input [3:0] ad, input [31:0] d);
      begin
         @(posedge core_clk);
         awAddr <= ad;
         wData <= d;
         {awValid, wValid, bReady} <= 3'h7;
         {pa, pw, pb} = 3'h7;
         n = 0;
         while (pa | pw | pb) begin
            @(posedge core_clk);
            rs = bResp;
            pb = pb & ~bValid;
            pa = pa & ~awReady;
            pw = pw & ~wReady;
            {awValid, wValid, bReady} <= {pa, pw, pb};
            hang(40);
         end
      end
   endtask
   task rdr(input [3:0] ad);
      begin
         @(posedge core_clk);
         arAddr <= ad;
         {arValid, rReady} <= 2'h3;
         {pa, pb} = 2'h3;
         n = 0;
         while (pa | pb) begin
            @(posedge core_clk);
            rd = rData;
            rs = rResp;
            pb = pb & ~rValid;
            pa = pa & ~arReady;
            {arValid, rReady} <= {pa, pb};
            hang(40);
         end
      end
   endtask
   task startup(input integer lo, input lng);
      begin
         @(posedge core_clk);
         longOpt <= lng;
         rst_b <= 1'b0;
         repeat (6) @(posedge core_clk);
         rst_b <= 1'b1;
         waitSig(2, 1'b0, 100);
         cmpIn("startup", lo, lo + 4, n);
      end
   endtask
   task regsAfterReset;
      begin
         rdr(ADR_SC);
         cmp("status", 32'h3, rd);
         rdr(ADR_WD);
         cmp("wdclear", 32'h0, rd);
         rdr(4'h2);
         cmp("badresp", `CTW_RESP_SLVERR, rs);
         wStrb <= 4'h0;
         wr(ADR_SC, 32'h30);
         wStrb <= 4'hf;
         rdr(ADR_SC);
         cmp("nostrobe", 32'h3, rd);
         for (i = 0; i < 4; i = i + 1) begin
            wr(ADR_SC, i | 32'h3c);
            rdr(ADR_SC);
            cmp("rate", i | 32'h30, rd & 32'h3f);
         end
         wr(ADR_SC, 32'h0f);
      end
   endtask
   task counterRate;
      integer c0, t0;
      begin
         rdr(`CTW_COUNT_VALUE_ADDR);
         c0 = rd;
         t0 = cyc;
         repeat (37) @(posedge core_clk);
         rdr(`CTW_COUNT_VALUE_ADDR);
         cmpIn("count", (cyc - t0) / 4, (cyc - t0 + 3) / 4,
               (rd - c0) & 255);
      end
   endtask
   task overflowFlag;
      begin
         wr(ADR_SC, 32'h2b);
         waitSig(0, 1'b1, 1100);
         a = cyc;
         wr(ADR_SC, 32'ha3);
         rdr(ADR_SC);
         cmp("ovfset", 32'ha3, rd & 32'hbf);
         wr(ADR_SC, 32'h2b);
         cmp("ovfirq", 32'h0, ovfIrq);
         waitSig(0, 1'b1, 1100);
         cmp("ovfper", 1024, cyc - a);
         wr(ADR_SC, 32'h03);
         rdr(ADR_SC);
         cmp("ovfmask", 32'h83, rd & 32'hbf);
         cmp("ovfoff", 32'h0, ovfIrq);
         wr(ADR_SC, 32'h0b);
      end
   endtask
   // watchdog cleared before each rate change, as software must
   task periodicRate;
      begin
         for (i = 0; i < 2; i = i + 1) begin
            wr(ADR_WD, 32'h0);
            wr(ADR_SC, 32'h14 | i);
            waitSig(1, 1'b1, 34000);
            a = cyc;
            wr(ADR_WD, 32'h0);
            wr(ADR_SC, 32'h14 | i);
            cmp("perirq", 32'h0, perIrq);
            waitSig(1, 1'b1, 34000);
            // 2^15 oscillator cycles are 2^14 bus cycles
            cmp("perper", 16384 << i, cyc - a);
            cmp("wdogok", 32'h0, devRst);
         end
      end
   endtask
   task stopWatchdog;
      begin
         wr(ADR_SC, 32'h0c);
         wr(ADR_WD, 32'h0);
         wr(`CTW_MODE_CONTROL_ADDR, 32'h1);
         haltOpt <= 1'b1;
         repeat (6) @(posedge core_clk);
         cmp("halt", 32'h0, stopAct);
         haltOpt <= 1'b0;
         repeat (6) @(posedge core_clk);
         cmp("stop", 32'h1, stopAct);
         a = 0;
         repeat (33000) @(negedge core_clk) a = a | devRst;
         cmp("stopwd", 32'h0, a);
         wr(`CTW_MODE_CONTROL_ADDR, 32'h0);
         a = cyc;
         waitSig(2, 1'b1, 135000);
         cmpIn("wdtime", 7 * 16384 - 8, 8 * 16384 + 8, cyc - a);
         waitSig(2, 1'b0, 100);
         rdr(ADR_SC);
         cmp("wdreset", 32'h3, rd);
      end
   endtask
   initial begin
      startup(16, 1'b0);
      regsAfterReset;
      counterRate;
      overflowFlag;
      periodicRate;
      stopWatchdog;
      startup(40, 1'b1);
      end_sim;
   end
endmodule
